// ===== sim_override_defines.vh
`ifndef SIM_OVERRIDE_DEFINES_VH
`define SIM_OVERRIDE_DEFINES_VH

// simulation function indices
`define FN_CURRENT 3'd0
`define FN_AOUT 3'd1
`define FN_AIN 3'd2
`define FN_SWITCH 3'd3
`define FN_THERM 3'd4
`define FN_COUNT 5

// setting write selectors; 0..4 are the duration of function 0..4
`define SEL_AOUT 4'h5
`define SEL_AIN 4'h6
`define SEL_SWITCH 4'h7
`define SEL_THERM 4'h8
`define SEL_GND 4'h9
`define SEL_VOLT 4'ha
`define SEL_POWER 4'hb

// enable duration in minutes
`define DUR_UNLIMITED 9'h000
`define DUR_MIN 9'h005
`define DUR_MAX 9'h12c
`define DUR_STEP 9'h005
`define DUR_DEFAULT 9'h00f

// forced analog output in percent
`define AOUT_MAX 7'h64
`define AOUT_OFF 7'h7f

// simulated analog input in mA
`define AIN_MIN 5'h04
`define AIN_MAX 5'h14
`define AIN_OFF 5'h1f

// simulated thermistor in ohms
`define THERM_MAX 15'h7530

// switch input bit positions, 1 = closed
`define SW_START_A 0
`define SW_START_B 1
`define SW_STOP 2
`define SW_CONT_A 3
`define SW_CONT_B 4
`define SW_ISOLATOR 5
`define SW_INTERLOCK1 6
`define SW_RESET 16'h0000

// timing
`define CLK_HZ 32'h02faf080
`define SECOND_CYCLES (`CLK_HZ * 32'h00000001)
`define MINUTE_S 6'h3c
`define NOTIFY_S 32'h00000003
`define NOTIFY_CYCLES (`NOTIFY_S * `CLK_HZ)

`endif

// ===== sim_timer.v
`timescale 1ns/1ps
`include "sim_override_defines.vh"

// per-function minute counter, cleared when the simulation is first enabled
module sim_timer #(
    parameter CNT_W = 9
) (
    // clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // control
    input wire start_i,
    input wire run_i,
    input wire minute_tick_i,
    input wire [CNT_W-1:0] limit_i,
    // status
    output wire expired_o
);
    reg [CNT_W-1:0] minutes;

    // saturates instead of wrapping so a long unlimited run cannot alias
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            minutes <= {CNT_W{1'b0}};
        end else if (start_i) begin
            minutes <= {CNT_W{1'b0}}; // RULE19
        end else if (run_i && minute_tick_i && (minutes != {CNT_W{1'b1}})) begin
            minutes <= minutes + {{(CNT_W-1){1'b0}}, 1'b1}; // RULE19
        end
    end

    // zero limit means unlimited
    assign expired_o = run_i && (limit_i != {CNT_W{1'b0}}) && (minutes >= limit_i); // RULE3 RULE5
endmodule

// ===== flash_notifier.v
`timescale 1ns/1ps
`include "sim_override_defines.vh"

// shows enabled or disabled notice for a fixed time after each change
module flash_notifier #(
    parameter [31:0] HOLD_CYCLES = `NOTIFY_CYCLES
) (
    // clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // watched enable
    input wire active_i,
    // notices
    output reg show_on_o,
    output reg show_off_o
);
    reg last;
    reg [31:0] count;

    // a new change restarts the notice, the newer one replaces the older
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            last <= 1'b0;
            count <= 32'h00000000;
            show_on_o <= 1'b0;
            show_off_o <= 1'b0;
        end else begin
            last <= active_i;
            if (active_i != last) begin
                show_on_o <= active_i; // RULE14
                show_off_o <= ~active_i; // RULE14
                count <= HOLD_CYCLES - 32'h00000001;
            end else if (count != 32'h00000000) begin
                count <= count - 32'h00000001;
            end else begin
                show_on_o <= 1'b0;
                show_off_o <= 1'b0;
            end
        end
    end
endmodule

// ===== test_simulation_override.v
`timescale 1ns/1ps
`include "sim_override_defines.vh"

// What this block does
// RULE1: analog output driven from forced value while output simulation is on.
// RULE2: each function has own duration, 5 to 300 minutes step 5, or unlimited.
// RULE3: when duration elapses since first enable, simulation turns off.
// RULE4: after power-up every simulation is off.
// RULE5: unlimited duration keeps simulation until switched off or power lost.
// RULE6: forced output accepted 0 to 100 percent step 1, or off.
// RULE7: analog input simulation substitutes programmed current for measured input.
// RULE8: simulated analog input accepted 4 to 20 mA step 1, or off.
// RULE9: switch simulation replaces every sensed switch with its simulated state.
// RULE10: simulated states held for starts, stop, contactors, isolator, interlocks 1-10.
// RULE11: simulated switch states processed exactly like real inputs.
// RULE12: thermistor simulation substitutes programmed resistance for measured reading.
// RULE13: simulated thermistor accepted 0 to 30000 ohms, processed like real.
// RULE14: each on or off change shows matching notice for 3 seconds.
// RULE15: simulated ground current, voltage, power accepted 0 to 65535.
// RULE16: simulated ground current applies only while current simulation is on.
// RULE17: every duration setting defaults to 15 minutes.
// RULE18: current simulation refused or cancelled while real current is present.
// RULE19: per-function minute counter on one-minute tick, cleared at enable.
// RULE20: switching a simulation off returns immediately to measured values.
module test_simulation_override #(
    parameter [31:0] SECOND_CYCLES = `SECOND_CYCLES,
    parameter [31:0] NOTIFY_CYCLES = `NOTIFY_CYCLES
) (
    // clock and reset
    input wire clk_sys_i,
    input wire reset_n_i,
    // on and off requests from keypad or serial port, one bit per function
    input wire [`FN_COUNT-1:0] sim_on_req_i,
    input wire [`FN_COUNT-1:0] sim_off_req_i,
    // setting writes
    input wire set_wr_i,
    input wire [3:0] set_sel_i,
    input wire [15:0] set_data_i,
    // protection conditions
    input wire current_present_i,
    input wire trip_i,
    // measured and computed quantities
    input wire [6:0] actual_aout_pct_i,
    input wire [4:0] actual_ain_ma_i,
    input wire [15:0] actual_switch_i,
    input wire [14:0] actual_therm_ohm_i,
    input wire [15:0] actual_gnd_a_i,
    input wire [15:0] actual_volt_i,
    input wire [15:0] actual_power_kw_i,
    // quantities used by the relay
    output reg [6:0] aout_pct_o,
    output reg [4:0] ain_ma_o,
    output reg [15:0] switch_o,
    output reg [14:0] therm_ohm_o,
    output reg [15:0] gnd_a_o,
    output reg [15:0] volt_o,
    output reg [15:0] power_kw_o,
    // status
    output reg [`FN_COUNT-1:0] sim_active_o,
    output wire [`FN_COUNT-1:0] notify_on_o,
    output wire [`FN_COUNT-1:0] notify_off_o,
    output reg set_reject_o
);
    reg [1:0] rst_sync;
    wire rst_n;
    reg [`FN_COUNT-1:0] sim_en;
    reg [`FN_COUNT-1:0] next_sim_en;
    reg [`FN_COUNT-1:0] start;
    wire [`FN_COUNT-1:0] expired;
    reg [8:0] duration [0:`FN_COUNT-1];
    reg [6:0] forced_output_percent;
    reg [4:0] sim_ain_ma;
    reg [15:0] sim_switch;
    reg [14:0] sim_therm_ohm;
    reg [15:0] sim_gnd_a;
    reg [15:0] sim_volt;
    reg [15:0] sim_power_kw;
    reg [31:0] sec_count;
    reg [5:0] sec_in_min;
    reg minute_tick;
    reg accept;
    integer i;
    integer k;

    // true when v lies between lo and hi inclusive
    function in_range;
        input [15:0] v;
        input [15:0] lo;
        input [15:0] hi;
        begin
            in_range = (v >= lo) && (v <= hi);
        end
    endfunction

    // reset released through two flops, asserted at once
    always @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // one-minute tick built from a seconds prescaler
    always @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            sec_count <= 32'h00000000;
            sec_in_min <= 6'h00;
            minute_tick <= 1'b0;
        end else begin
            minute_tick <= 1'b0;
            if (sec_count == SECOND_CYCLES - 32'h00000001) begin
                sec_count <= 32'h00000000;
                if (sec_in_min == `MINUTE_S - 6'h01) begin
                    sec_in_min <= 6'h00;
                    minute_tick <= 1'b1; // RULE19
                end else begin
                    sec_in_min <= sec_in_min + 6'h01;
                end
            end else begin
                sec_count <= sec_count + 32'h00000001;
            end
        end
    end

    // range check of a setting write; refused writes leave the value alone
    always @* begin
        accept = 1'b0;
        case (set_sel_i)
            4'h0, 4'h1, 4'h2, 4'h3, 4'h4: begin
                accept = (set_data_i[8:0] == `DUR_UNLIMITED && set_data_i[15:9] == 7'h00) ||
                         (in_range(set_data_i, {7'h00, `DUR_MIN}, {7'h00, `DUR_MAX}) &&
                          (set_data_i % {7'h00, `DUR_STEP}) == 16'h0000); // RULE2
            end
            `SEL_AOUT: begin
                accept = in_range(set_data_i, 16'h0000, {9'h000, `AOUT_MAX}) ||
                         set_data_i == {9'h000, `AOUT_OFF}; // RULE6
            end
            `SEL_AIN: begin
                accept = in_range(set_data_i, {11'h000, `AIN_MIN}, {11'h000, `AIN_MAX}) ||
                         set_data_i == {11'h000, `AIN_OFF}; // RULE8
            end
            `SEL_SWITCH: begin
                accept = 1'b1; // RULE10
            end
            `SEL_THERM: begin
                accept = in_range(set_data_i, 16'h0000, {1'b0, `THERM_MAX}); // RULE13
            end
            `SEL_GND, `SEL_VOLT, `SEL_POWER: begin
                accept = 1'b1; // RULE15
            end
            default: begin
                accept = 1'b0;
            end
        endcase
    end

    // setting storage; writes are accepted at any time, even mid-simulation
    always @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            for (k = 0; k < `FN_COUNT; k = k + 1) begin
                duration[k] <= `DUR_DEFAULT; // RULE17
            end
            forced_output_percent <= `AOUT_OFF;
            sim_ain_ma <= `AIN_OFF;
            sim_switch <= `SW_RESET;
            sim_therm_ohm <= 15'h0000;
            sim_gnd_a <= 16'h0000;
            sim_volt <= 16'h0000;
            sim_power_kw <= 16'h0000;
            set_reject_o <= 1'b0;
        end else begin
            set_reject_o <= set_wr_i && !accept;
            if (set_wr_i && accept) begin
                case (set_sel_i)
                    4'h0, 4'h1, 4'h2, 4'h3, 4'h4: duration[set_sel_i[2:0]] <= set_data_i[8:0]; // RULE2
                    `SEL_AOUT: forced_output_percent <= set_data_i[6:0]; // RULE6
                    `SEL_AIN: sim_ain_ma <= set_data_i[4:0]; // RULE8
                    `SEL_SWITCH: sim_switch <= set_data_i; // RULE10
                    `SEL_THERM: sim_therm_ohm <= set_data_i[14:0]; // RULE13
                    `SEL_GND: sim_gnd_a <= set_data_i; // RULE15
                    `SEL_VOLT: sim_volt <= set_data_i; // RULE15
                    `SEL_POWER: sim_power_kw <= set_data_i; // RULE15
                    default: sim_power_kw <= sim_power_kw;
                endcase
            end
        end
    end

    // enable update; an accepted on request wins over every clearing cause
    always @* begin
        next_sim_en = sim_en;
        start = {`FN_COUNT{1'b0}};
        for (i = 0; i < `FN_COUNT; i = i + 1) begin
            if (sim_off_req_i[i] || expired[i]) begin
                next_sim_en[i] = 1'b0; // RULE3 RULE5
            end
            if (i == `FN_CURRENT && (current_present_i || trip_i)) begin
                next_sim_en[i] = 1'b0; // RULE18
            end
            if (sim_on_req_i[i] && !(i == `FN_CURRENT && current_present_i)) begin
                next_sim_en[i] = 1'b1; // RULE18
                start[i] = !sim_en[i] || expired[i]; // RULE19
            end
        end
    end

    always @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            sim_en <= {`FN_COUNT{1'b0}}; // RULE4
            sim_active_o <= {`FN_COUNT{1'b0}};
        end else begin
            sim_en <= next_sim_en;
            sim_active_o <= next_sim_en;
        end
    end

    // one timer and one notifier per function
    genvar g;
    generate
        for (g = 0; g < `FN_COUNT; g = g + 1) begin : fn
            sim_timer #(
                .CNT_W(9)
            ) u_timer (
                .clk_i(clk_sys_i),
                .rst_n_i(rst_n),
                .start_i(start[g]),
                .run_i(sim_en[g]),
                .minute_tick_i(minute_tick),
                .limit_i(duration[g]),
                .expired_o(expired[g])
            );
            flash_notifier #(
                .HOLD_CYCLES(NOTIFY_CYCLES)
            ) u_notice (
                .clk_i(clk_sys_i),
                .rst_n_i(rst_n),
                .active_i(sim_en[g]),
                .show_on_o(notify_on_o[g]),
                .show_off_o(notify_off_o[g])
            );
        end
    endgenerate

    // substitution muxes; follow the next enable so off takes effect at once
    always @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            aout_pct_o <= 7'h00;
            ain_ma_o <= 5'h00;
            switch_o <= 16'h0000;
            therm_ohm_o <= 15'h0000;
            gnd_a_o <= 16'h0000;
            volt_o <= 16'h0000;
            power_kw_o <= 16'h0000;
        end else begin
            // an off forced value leaves the computed output in place
            if (next_sim_en[`FN_AOUT] && forced_output_percent != `AOUT_OFF) begin
                aout_pct_o <= forced_output_percent; // RULE1
            end else begin
                aout_pct_o <= actual_aout_pct_i; // RULE20
            end
            if (next_sim_en[`FN_AIN] && sim_ain_ma != `AIN_OFF) begin
                ain_ma_o <= sim_ain_ma; // RULE7
            end else begin
                ain_ma_o <= actual_ain_ma_i; // RULE20
            end
            // same bit order as the real inputs so downstream logic cannot tell
            switch_o <= next_sim_en[`FN_SWITCH] ? sim_switch : actual_switch_i; // RULE9 RULE11
            therm_ohm_o <= next_sim_en[`FN_THERM] ? sim_therm_ohm : actual_therm_ohm_i; // RULE12 RULE13
            gnd_a_o <= next_sim_en[`FN_CURRENT] ? sim_gnd_a : actual_gnd_a_i; // RULE16
            volt_o <= next_sim_en[`FN_CURRENT] ? sim_volt : actual_volt_i;
            power_kw_o <= next_sim_en[`FN_CURRENT] ? sim_power_kw : actual_power_kw_i;
        end
    end
endmodule

// ===== sim_override_assertions.sv
`timescale 1ns/1ps
`include "sim_override_defines.vh"

// port-level checks of the simulation override block
module sim_override_assertions (
    // clock and reset
    input wire clk_sys_i,
    input wire reset_n_i,
    // requests and settings
    input wire [`FN_COUNT-1:0] sim_on_req_i,
    input wire [`FN_COUNT-1:0] sim_off_req_i,
    input wire set_wr_i,
    input wire [3:0] set_sel_i,
    input wire [15:0] set_data_i,
    input wire current_present_i,
    input wire trip_i,
    input wire [6:0] actual_aout_pct_i,
    input wire [14:0] actual_therm_ohm_i,
    // results
    input wire [6:0] aout_pct_o,
    input wire [14:0] therm_ohm_o,
    input wire [`FN_COUNT-1:0] sim_active_o,
    input wire [`FN_COUNT-1:0] notify_on_o,
    input wire [`FN_COUNT-1:0] notify_off_o,
    input wire set_reject_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);
    reg [1:0] settle;
    wire ready = (settle == 2'h3);

    // internal reset lags the pin by two edges, so hold checks off for three edges
    always @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) settle <= 2'h0;
        else if (!ready) settle <= settle + 2'h1;
    end

    a_on_takes: assert property (ready && sim_on_req_i[1] |=> sim_active_o[1])
        else $error("output simulation did not start");
    a_aout_actual: assert property (ready && !sim_active_o[1] |-> aout_pct_o == $past(actual_aout_pct_i))
        else $error("analog output not actual while off");
    a_therm_actual: assert property (ready && !sim_active_o[4] |-> therm_ohm_o == $past(actual_therm_ohm_i))
        else $error("thermistor not actual while off");
    a_current_cancel: assert property (current_present_i |=> !sim_active_o[0])
        else $error("current simulation with real current");
    a_trip_cancel: assert property (trip_i |=> !sim_active_o[0])
        else $error("current simulation kept after trip");
    a_notify_on: assert property ($rose(sim_active_o[2]) |=> notify_on_o[2] [*8])
        else $error("enabled notice too short");
    a_notify_off: assert property ($fell(sim_active_o[1]) |=> notify_off_o[1])
        else $error("disabled notice missing");
    a_off_req: assert property (ready && sim_active_o[3] && sim_off_req_i[3] && !sim_on_req_i[3]
        |=> !sim_active_o[3])
        else $error("off request ignored");
    a_no_self_on: assert property (ready && !sim_active_o[3] && !sim_on_req_i[3] |=> !sim_active_o[3])
        else $error("switch simulation turned itself on");
    a_reject_dur: assert property (ready && set_wr_i && set_sel_i == 4'h0 && set_data_i == 16'h0007
        |=> set_reject_o)
        else $error("bad duration accepted");

    c_cur_on: cover property ($rose(sim_active_o[0]));
    c_timeout: cover property ($fell(sim_active_o[1]));
    c_reject: cover property (set_reject_o);
endmodule

bind test_simulation_override sim_override_assertions i_chk (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .sim_on_req_i(sim_on_req_i),
    .sim_off_req_i(sim_off_req_i), .set_wr_i(set_wr_i), .set_sel_i(set_sel_i),
    .set_data_i(set_data_i), .current_present_i(current_present_i), .trip_i(trip_i),
    .actual_aout_pct_i(actual_aout_pct_i), .actual_therm_ohm_i(actual_therm_ohm_i),
    .aout_pct_o(aout_pct_o), .therm_ohm_o(therm_ohm_o), .sim_active_o(sim_active_o),
    .notify_on_o(notify_on_o), .notify_off_o(notify_off_o), .set_reject_o(set_reject_o));

// ===== keypad_host.sv
`timescale 1ns/1ps

// operator keypad and serial host: one-cycle requests and setting writes
module keypad_host (
    // clock
    input wire clk_i,
    // requests
    output logic [4:0] on_req_o,
    output logic [4:0] off_req_o,
    output logic wr_o,
    output logic [3:0] sel_o,
    output logic [15:0] data_o
);
    initial begin
        on_req_o = 5'h00;
        off_req_o = 5'h00;
        wr_o = 1'b0;
        sel_o = 4'h0;
        data_o = 16'h0000;
    end

    // released lines show the inverse so a stale value never looks valid
    task set_value(input logic [3:0] sel, input logic [15:0] data);
        @(posedge clk_i);
        wr_o <= 1'b1;
        sel_o <= sel;
        data_o <= data;
        @(posedge clk_i);
        wr_o <= 1'b0;
        sel_o <= ~sel;
        data_o <= ~data;
    endtask

    task turn(input logic on, input logic [4:0] mask);
        @(posedge clk_i);
        if (on) on_req_o <= mask;
        else off_req_o <= mask;
        @(posedge clk_i);
        on_req_o <= 5'h00;
        off_req_o <= 5'h00;
    endtask
endmodule

// ===== test_test_simulation_override.sv
`timescale 1ns/1ps
`include "sim_override_defines.vh"

module test_test_simulation_override;
    localparam int MIN = 240; // one minute with four-cycle seconds
    logic clk = 1'b0, rst_n = 1'b0, cur = 1'b0, trip = 1'b0;
    logic [4:0] on_req, off_req, active, n_on, n_off;
    logic wr, rej;
    logic [3:0] sel;
    logic [15:0] data, sw, gnd, volt, pwr;
    logic [6:0] aout;
    logic [4:0] ain;
    logic [14:0] therm;
    // measured values are bench variables so the pass-through paths can be moved
    logic [6:0] act_aout = 7'h22;
    logic [4:0] act_ain = 5'h09;
    logic [15:0] act_sw = 16'h0f0f, act_gnd = 16'h0011, act_volt = 16'h0222, act_pwr = 16'h0333;
    logic [14:0] act_therm = 15'h1234;
    int bad_count = 0, checks_done = 0, cyc = 0;

    keypad_host i_host (.clk_i(clk), .on_req_o(on_req), .off_req_o(off_req), .wr_o(wr), .sel_o(sel),
        .data_o(data));
    test_simulation_override #(.SECOND_CYCLES(32'h00000004), .NOTIFY_CYCLES(32'h0000000a)) i_dut (
        .clk_sys_i(clk), .reset_n_i(rst_n), .sim_on_req_i(on_req), .sim_off_req_i(off_req),
        .set_wr_i(wr), .set_sel_i(sel), .set_data_i(data), .current_present_i(cur), .trip_i(trip),
        .actual_aout_pct_i(act_aout), .actual_ain_ma_i(act_ain), .actual_switch_i(act_sw),
        .actual_therm_ohm_i(act_therm), .actual_gnd_a_i(act_gnd), .actual_volt_i(act_volt),
        .actual_power_kw_i(act_pwr), .aout_pct_o(aout), .ain_ma_o(ain), .switch_o(sw),
        .therm_ohm_o(therm), .gnd_a_o(gnd), .volt_o(volt), .power_kw_o(pwr), .sim_active_o(active),
        .notify_on_o(n_on), .notify_off_o(n_off), .set_reject_o(rej));

    initial begin
        forever #10 clk = ~clk;
    end

    // hang guard, well beyond the twenty-three simulated minutes
    always @(posedge clk) begin
        cyc++;
        if (cyc == 8000) begin
            bad_count++;
            tally_and_finish();
        end
    end

    task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task pause(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // refusal is registered on the edge that takes the write
    task put(input logic [3:0] s, input logic [15:0] d, input logic bad);
        i_host.set_value(s, d);
        #1;
        check("reject", {15'h0000, rej}, {15'h0000, bad});
    endtask

    task tally_and_finish;
        if (bad_count == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        pause(3);
        check("active", {11'h000, active}, 16'h0000);
        check("aout", {9'h000, aout}, 16'h0022);
        put(4'h0, 16'h0007, 1'b1);
        put(4'h1, 16'h0005, 1'b0);
        put(4'h2, 16'h0000, 1'b0);
        put(`SEL_AOUT, 16'h0065, 1'b1);
        put(`SEL_AOUT, 16'h0064, 1'b0);
        put(`SEL_AIN, 16'h0003, 1'b1);
        put(`SEL_AIN, 16'h0014, 1'b0);
        put(`SEL_THERM, 16'h7531, 1'b1);
        put(`SEL_THERM, 16'h7530, 1'b0);
        put(`SEL_SWITCH, 16'ha5c3, 1'b0);
        put(`SEL_GND, 16'hffff, 1'b0);
        put(`SEL_VOLT, 16'h1234, 1'b0);
        put(`SEL_POWER, 16'h4321, 1'b0);
        put(4'hc, 16'h0000, 1'b1);
        pause(2);
        check("gnd", gnd, 16'h0011);
        check("volt", volt, 16'h0222);
        i_host.turn(1'b1, 5'h1e);
        pause(1);
        check("active", {11'h000, active}, 16'h001e);
        check("aout", {9'h000, aout}, 16'h0064);
        check("ain", {11'h000, ain}, 16'h0014);
        check("switch", sw, 16'ha5c3);
        check("therm", {1'b0, therm}, 16'h7530);
        pause(1);
        check("notice on", {11'h000, n_on}, 16'h001e);
        cur <= 1'b1;
        i_host.turn(1'b1, 5'h01);
        pause(2);
        check("active", {11'h000, active}, 16'h001e);
        cur <= 1'b0;
        i_host.turn(1'b1, 5'h01);
        pause(2);
        check("gnd", gnd, 16'hffff);
        check("volt", volt, 16'h1234);
        check("power", pwr, 16'h4321);
        trip <= 1'b1;
        pause(2);
        check("active", {11'h000, active}, 16'h001e);
        check("gnd", gnd, 16'h0011);
        check("power", pwr, 16'h0333);
        trip <= 1'b0;
        i_host.turn(1'b0, 5'h08);
        pause(1);
        check("switch", sw, 16'h0f0f);
        pause(1);
        check("notice off", {15'h0000, n_off[3]}, 16'h0001);
        // a moving computed value must not leak through while forced
        act_aout <= 7'h33;
        pause(1);
        check("aout", {9'h000, aout}, 16'h0064);
        pause(6 * MIN);
        check("active", {11'h000, active}, 16'h0014);
        check("aout", {9'h000, aout}, 16'h0033);
        pause(7 * MIN);
        check("active", {11'h000, active}, 16'h0014);
        pause(4 * MIN);
        check("active", {11'h000, active}, 16'h0004);
        i_host.turn(1'b0, 5'h04);
        pause(1);
        check("active", {11'h000, active}, 16'h0000);
        check("ain", {11'h000, ain}, 16'h0009);
        // re-enable clears the minute count, so two short runs never add up
        i_host.turn(1'b1, 5'h02);
        pause(3 * MIN);
        i_host.turn(1'b0, 5'h02);
        i_host.turn(1'b1, 5'h02);
        pause(3 * MIN);
        check("active", {11'h000, active}, 16'h0002);
        check("aout", {9'h000, aout}, 16'h0064);
        // power cycle in mid-simulation drops every enable
        rst_n <= 1'b0;
        pause(4);
        rst_n <= 1'b1;
        pause(3);
        check("active", {11'h000, active}, 16'h0000);
        check("aout", {9'h000, aout}, 16'h0033);
        tally_and_finish();
    end
endmodule
